//--- hw/rtcsc_pkg.sv
// Constants, carrier structs and state layout for the select and clock-out block.
// Assumes one 100 MHz clock domain and pins that are not yet synchronised.
package rtcsc_pkg;

  // Timing of the internal crystal-rate square wave
  localparam int unsigned MCLK_HZ = 100_000_000;
  localparam int unsigned XTAL_HZ = 32_768;
  localparam logic [26:0] PHASE_WRAP = 27'(MCLK_HZ);
  localparam logic [26:0] PHASE_STEP = 27'(2 * XTAL_HZ);

  // Register file geometry
  localparam int REG_COUNT = 16;
  localparam int NIBBLE_W = 4;
  localparam int ADDR_W = 4;
  localparam int CHAIN_W = 16;

  // Output-control register: enable bit and divider field
  localparam logic [3:0] CTRL_IDX = 4'hf;
  localparam int OUT_ENABLE_BIT = 3;
  localparam int DIV_MSB = 2;
  localparam int DIV_LSB = 0;

  // Reset values of the pin drivers (enables are active low)
  localparam logic OE_N_RST = 1'b1;
  localparam logic [3:0] NIBBLE_RST = 4'h0;

  // Sampled pin group
  typedef struct packed {
    logic selNPrimary;
    logic selHighSecondary;
    logic freqSource;
    logic readN;
    logic writeN;
    logic [ADDR_W-1:0] regNumber;
    logic [NIBBLE_W-1:0] nibble;
  } rtcsc_pins_type;

  // Whole module state
  typedef struct packed {
    rtcsc_pins_type sync1;
    rtcsc_pins_type sync2;
    logic writePrev;
    logic armed;
    logic [REG_COUNT-1:0][NIBBLE_W-1:0] regs;
    logic [26:0] phase;
    logic baseClk;
    logic [CHAIN_W-1:0] chain;
    logic [NIBBLE_W-1:0] nibbleOut;
    logic nibbleOeN;
    logic clockOut;
    logic clockOeN;
  } rtcsc_state_type;

endpackage : rtcsc_pkg

//--- hw/rtcsc_top.sv
// Chip-select decoding, nibble register port and clock-output gating.
// Assumes host strobes are asynchronous to mclk and slow against 10 ns;
// the pin wire level is resolved outside from the active-low enables.
`timescale 1ns/1ns

module rtcsc_top
  import rtcsc_pkg::*;
#(
  parameter bit HAS_FREQ_PIN = 1'b1
) (
  // Clock, reset, freeze
  input wire logic mclk,
  input wire logic rst,
  input wire logic ce,
  // Host selects and strobes
  input wire logic selectNPrimary,
  input wire logic selectHighSecondary,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic [3:0] registerNumberIn,
  // Nibble bus
  input wire logic [3:0] nibbleBusIn,
  output logic [3:0] nibbleBusOut,
  output logic nibbleBusOeN,
  // Frequency output
  input wire logic freqSourcePin,
  output logic clockOutPin,
  output logic clockOutOeN
);

  rtcsc_state_type s_q;
  rtcsc_state_type s_d;
  rtcsc_pins_type pinsIn;
  logic writeRise;
  logic accessNow;

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Both selects in their active state and power-on arming done
  function automatic logic accessOk(input rtcsc_pins_type p, input logic armed);
    accessOk = armed && !p.selNPrimary && p.selHighSecondary;
  endfunction : accessOk

  // Divider field 0 gives the crystal rate, n gives rate / 2^n
  function automatic logic freqSel(input logic base, input logic [CHAIN_W-1:0] chain,
                                   input logic [2:0] div);
    if (div == 3'h0) begin
      freqSel = base;
    end else begin
      freqSel = chain[div - 3'h1];
    end
  endfunction : freqSel

  ////////////////////////////////////////////////////////////////////////////////
  // Pin gathering; the short package ties the source pin high
  always_comb begin
    pinsIn.selNPrimary = selectNPrimary;
    pinsIn.selHighSecondary = selectHighSecondary;
    pinsIn.freqSource = HAS_FREQ_PIN ? freqSourcePin : 1'b1;
    pinsIn.readN = readStrobeN;
    pinsIn.writeN = writeStrobeN;
    pinsIn.regNumber = registerNumberIn;
    pinsIn.nibble = nibbleBusIn;
  end

  // Edge and access seen on the second synchroniser stage only
  assign writeRise = s_q.sync2.writeN && !s_q.writePrev;
  assign accessNow = accessOk(s_q.sync2, s_q.armed);

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic; everything holds while ce is low
  always_comb begin
    s_d = s_q;
    if (ce) begin
      s_d.sync1 = pinsIn;
      s_d.sync2 = s_q.sync1;
      s_d.writePrev = s_q.sync2.writeN;
      // A host that powered up with the select low must raise it once first
      if (s_q.sync2.selNPrimary) begin
        s_d.armed = 1'b1;
      end
      // Store on the strobe's rising edge at the addressed register
      if (writeRise && accessNow) begin
        s_d.regs[s_q.sync2.regNumber] = s_q.sync2.nibble;
      end
      // Crystal-rate square wave from a phase accumulator, no drift over time
      if (s_q.phase + PHASE_STEP >= PHASE_WRAP) begin
        s_d.phase = s_q.phase + PHASE_STEP - PHASE_WRAP;
        s_d.baseClk = !s_q.baseClk;
        if (!s_q.baseClk) begin
          s_d.chain = s_q.chain + 16'h0001;
        end
      end else begin
        s_d.phase = s_q.phase + PHASE_STEP;
      end
      // Read drive; both strobes low is illegal so a write wins the bus off
      if (accessNow && !s_q.sync2.readN && s_q.sync2.writeN) begin
        s_d.nibbleOeN = 1'b0;
        s_d.nibbleOut = s_q.regs[s_q.sync2.regNumber];
      end else begin
        s_d.nibbleOeN = 1'b1;
        s_d.nibbleOut = NIBBLE_RST;
      end
      // Clock output gating, independent of the primary select
      if (!s_q.sync2.selHighSecondary) begin
        s_d.clockOeN = 1'b1;
        s_d.clockOut = 1'b0;
      end else if (!s_q.sync2.freqSource) begin
        s_d.clockOeN = 1'b0;
        s_d.clockOut = s_d.baseClk;
      end else if (s_q.regs[CTRL_IDX][OUT_ENABLE_BIT]) begin
        s_d.clockOeN = 1'b0;
        // Uses the next base and chain so the pin never lags the crystal edge
        s_d.clockOut = freqSel(s_d.baseClk, s_d.chain, s_q.regs[CTRL_IDX][DIV_MSB:DIV_LSB]);
      end else begin
        s_d.clockOeN = 1'b1;
        s_d.clockOut = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; drivers start released
  always_ff @(posedge mclk) begin
    if (rst) begin
      s_q <= '0;
      s_q.nibbleOeN <= OE_N_RST;
      s_q.clockOeN <= OE_N_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state flip-flops
  assign nibbleBusOut = s_q.nibbleOut;
  assign nibbleBusOeN = s_q.nibbleOeN;
  assign clockOutPin = s_q.clockOut;
  assign clockOutOeN = s_q.clockOeN;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence wrRiseSelected;
    ce && writeRise && accessNow;
  endsequence

  sequence secondaryHigh;
    s_q.sync2.selHighSecondary;
  endsequence

  chk_access_gate: assert property (@(posedge mclk) disable iff (rst)
    ce && (s_q.sync2.selNPrimary || !s_q.sync2.selHighSecondary) |=> nibbleBusOeN)
    else $error("nibble bus driven without both selects active");

  chk_fixed_rate: assert property (@(posedge mclk) disable iff (rst)
    secondaryHigh and (ce && !s_q.sync2.freqSource)
    |=> !clockOutOeN && clockOutPin == s_q.baseClk)
    else $error("fixed crystal rate not on clock output");

  chk_enable_off: assert property (@(posedge mclk) disable iff (rst)
    secondaryHigh and (ce && s_q.sync2.freqSource && !s_q.regs[CTRL_IDX][OUT_ENABLE_BIT])
    |=> clockOutOeN)
    else $error("clock output driven with enable bit clear");

  chk_divided_rate: assert property (@(posedge mclk) disable iff (rst)
    (secondaryHigh and (ce && s_q.sync2.freqSource && s_q.regs[CTRL_IDX][OUT_ENABLE_BIT]))
    ##1 ce
    |-> !clockOutOeN && clockOutPin == freqSel($past(s_d.baseClk), $past(s_d.chain),
        $past(s_q.regs[CTRL_IDX][DIV_MSB:DIV_LSB])))
    else $error("divided rate missing on clock output");

  chk_secondary_low: assert property (@(posedge mclk) disable iff (rst)
    ce && !s_q.sync2.selHighSecondary |=> clockOutOeN)
    else $error("clock output driven with secondary select low");

  chk_primary_free: assert property (@(posedge mclk) disable iff (rst)
    secondaryHigh and (ce && s_q.sync2.selNPrimary && !s_q.sync2.freqSource)
    |=> !clockOutOeN)
    else $error("clock output blocked by primary select");

  chk_idle_float: assert property (@(posedge mclk) disable iff (rst)
    clockOutOeN |-> clockOutPin == 1'b0 && $stable(clockOutOeN) || $rose(clockOutOeN))
    else $error("idle clock output not parked");

  chk_read_data: assert property (@(posedge mclk) disable iff (rst)
    ce && accessNow && !s_q.sync2.readN && s_q.sync2.writeN
    |=> !nibbleBusOeN && nibbleBusOut == $past(s_q.regs[s_q.sync2.regNumber]))
    else $error("read did not return addressed nibble");

  chk_write_store: assert property (@(posedge mclk) disable iff (rst)
    wrRiseSelected |=> s_q.regs[$past(s_q.sync2.regNumber)] == $past(s_q.sync2.nibble))
    else $error("write edge did not store nibble");

  chk_arm_first: assert property (@(posedge mclk) disable iff (rst)
    ce && !s_q.armed |=> nibbleBusOeN)
    else $error("access before primary select seen high");

  chk_bus_quiet: assert property (@(posedge mclk) disable iff (rst)
    ce && s_q.sync2.readN |=> nibbleBusOeN [*1] ##0 nibbleBusOut == NIBBLE_RST)
    else $error("nibble bus driven outside a read");

  ////////////////////////////////////////////////////////////////////////////////
  // Freeze, arming, parking and synchroniser checks

  // One cycle in which the clock enable is low
  sequence frozenCycle;
    !ce;
  endsequence

  // One cycle of a clean selected read, write strobe high
  sequence selectedRead;
    ce && accessNow && !s_q.sync2.readN && s_q.sync2.writeN;
  endsequence

  // Two running cycles in a row let a pin reach the second stage
  sequence twoRunning;
    ce ##1 ce;
  endsequence

  // Freezing must hold the nibble bus drivers exactly
  chk_freeze_bus: assert property (@(posedge mclk) disable iff (rst)
    frozenCycle |=> $stable(nibbleBusOeN) && $stable(nibbleBusOut))
    else $error("nibble bus moved while frozen");

  // Freezing must hold the clock output, even mid-period
  chk_freeze_clock: assert property (@(posedge mclk) disable iff (rst)
    frozenCycle |=> $stable(clockOutOeN) && $stable(clockOutPin))
    else $error("clock output moved while frozen");

  // No write may land while frozen, whatever the strobes do
  chk_freeze_regs: assert property (@(posedge mclk) disable iff (rst)
    frozenCycle |=> $stable(s_q.regs))
    else $error("register file changed while frozen");

  // The accumulator and arming flag also stop
  chk_freeze_arm: assert property (@(posedge mclk) disable iff (rst)
    frozenCycle |=> $stable(s_q.armed) && $stable(s_q.phase))
    else $error("phase or arming moved while frozen");

  // A released bus shows a fixed level, so a stale nibble never leaks
  chk_read_park: assert property (@(posedge mclk) disable iff (rst)
    nibbleBusOeN |-> nibbleBusOut == NIBBLE_RST)
    else $error("released nibble bus not parked");

  // A low write strobe keeps the device off the bus
  chk_write_quiet: assert property (@(posedge mclk) disable iff (rst)
    ce && !s_q.sync2.writeN |=> nibbleBusOeN)
    else $error("nibble bus driven during write strobe");

  // A write edge with the wrong selects leaves every register alone
  chk_refuse_store: assert property (@(posedge mclk) disable iff (rst)
    ce && writeRise && !accessNow |=> $stable(s_q.regs))
    else $error("refused write changed a register");

  // Only the rising edge of the write strobe stores
  chk_store_edge: assert property (@(posedge mclk) disable iff (rst)
    ce && !writeRise |=> $stable(s_q.regs))
    else $error("register changed without write edge");

  // Seeing the primary select high arms the port
  chk_arm_sets: assert property (@(posedge mclk) disable iff (rst)
    ce && s_q.sync2.selNPrimary |=> s_q.armed)
    else $error("primary select high did not arm access");

  // Once armed, only reset disarms
  chk_arm_sticky: assert property (@(posedge mclk) disable iff (rst)
    s_q.armed |=> s_q.armed)
    else $error("access arming lost");

  // Logic reads pins two running edges after they are sampled
  chk_sync_depth: assert property (@(posedge mclk) disable iff (rst)
    twoRunning |=> s_q.sync2 == $past(pinsIn, 2))
    else $error("pin synchroniser depth wrong");

  // Edge detection compares against the previous second-stage sample
  chk_write_prev: assert property (@(posedge mclk) disable iff (rst)
    ce |=> s_q.writePrev == $past(s_q.sync2.writeN))
    else $error("write strobe history wrong");

  // Without the source pin the divider path is always chosen
  chk_tied_high: assert property (@(posedge mclk) disable iff (rst)
    (ce && !HAS_FREQ_PIN) ##1 ce |=> s_q.sync2.freqSource)
    else $error("missing source pin not tied high");

  // Accumulator stays below its wrap, else the crystal rate drifts
  chk_phase_range: assert property (@(posedge mclk) disable iff (rst)
    s_q.phase < PHASE_WRAP)
    else $error("phase accumulator out of range");

  // Divider chain advances once per crystal period
  chk_chain_step: assert property (@(posedge mclk) disable iff (rst)
    ce && !s_q.baseClk && s_d.baseClk |=> s_q.chain == $past(s_q.chain) + 16'h0001)
    else $error("divider chain did not advance");

  // An undriven clock pin is parked low inside the block
  chk_clock_parked: assert property (@(posedge mclk) disable iff (rst)
    clockOutOeN |-> !clockOutPin)
    else $error("released clock output not parked");

  // A lasting selected read keeps the bus driven
  chk_read_held: assert property (@(posedge mclk) disable iff (rst)
    selectedRead ##1 selectedRead |=> !nibbleBusOeN)
    else $error("selected read lost the bus");

  // Enable bit clear parks the pin as well as releasing it
  chk_enable_pin: assert property (@(posedge mclk) disable iff (rst)
    ce && s_q.sync2.selHighSecondary && s_q.sync2.freqSource
    && !s_q.regs[CTRL_IDX][OUT_ENABLE_BIT] |=> !clockOutPin)
    else $error("clock pin active with enable bit clear");

endmodule : rtcsc_top

//--- testbench/rtcsc_host.sv
// Host model for the nibble port: primary select, strobes, address and data.
// Assumes the bench calls its tasks right after an mclk edge.
`timescale 1ns/1ns
module rtcsc_host (
  // Clock and read-back
  input wire logic mclk,
  input wire logic [3:0] rdData,
  input wire logic rdOeN,
  // Host pins
  output logic selN = 1'b1,
  output logic rdN = 1'b1,
  output logic wrN = 1'b1,
  output logic [3:0] addr = 4'h0,
  output logic [3:0] dout = 4'h0
);
  //////////////////////////////////////////////////////////////////////
  // Wide spacing keeps the synchronisers' three-edge latency covered
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Only one strobe is ever low at a time
  task automatic wr(input logic pri, input logic [3:0] a, input logic [3:0] d);
    selN <= pri;
    addr <= a;
    dout <= d;
    cyc(5);
    wrN <= 1'b0;
    cyc(5);
    wrN <= 1'b1;
    cyc(5);
    dout <= ~d; // Released data does not keep its value
    selN <= 1'b1;
    cyc(3);
  endtask : wr

  // Sample well after the three-edge answer
  task automatic rd(input logic [3:0] a, output logic [3:0] d, output logic oeN);
    selN <= 1'b0;
    addr <= a;
    rdN <= 1'b0;
    cyc(6);
    d = rdData;
    oeN = rdOeN;
    rdN <= 1'b1;
    selN <= 1'b1;
    cyc(5);
  endtask : rd
endmodule : rtcsc_host

//--- testbench/rtcsc_tb_top.sv
// Self-checking bench for the select and clock-out block.
// Assumes the host model drives the port and bench owns the rest.
`timescale 1ns/1ns
module rtcsc_tb_top;
  import rtcsc_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, ce = 1'b1, srcPin = 1'b0, selHi = 1'b0;
  logic selN, rdN, wrN, busOeN, clkPin, clkOeN, oe;
  logic [3:0] addr, dout, busOut, d;
  int fails = 0, samples_checked = 0, toggles;

  //////////////////////////////////////////////////////////////////////
  // Design and host
  rtcsc_top i_rtcsc_top (.mclk(mclk), .rst(rst), .ce(ce), .selectNPrimary(selN),
    .selectHighSecondary(selHi), .readStrobeN(rdN), .writeStrobeN(wrN),
    .registerNumberIn(addr), .nibbleBusIn(dout), .nibbleBusOut(busOut),
    .nibbleBusOeN(busOeN), .freqSourcePin(srcPin), .clockOutPin(clkPin),
    .clockOutOeN(clkOeN));
  rtcsc_host i_rtcsc_host (.mclk(mclk), .rdData(busOut), .rdOeN(busOeN), .selN(selN),
    .rdN(rdN), .wrN(wrN), .addr(addr), .dout(dout));

  // Clock at 100 MHz
  initial begin
    forever #5 mclk = ~mclk;
  end

  //////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_range(input string what, input int lo, input int hi, input int got);
    samples_checked++;
    if (got < lo || got > hi) begin
      fails++;
      $display("unexpected %s: expected %0d to %0d seen %0d", what, lo, hi, got);
    end
  endtask : chk_range

  // Counts clock pin changes over n edges
  task automatic count_toggles(input int n, output int t);
    logic prev;
    t = 0;
    prev = clkPin;
    repeat (n) begin
      @(posedge mclk);
      if (clkPin !== prev) t++;
      prev = clkPin;
    end
  endtask : count_toggles

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  //////////////////////////////////////////////////////////////////////
  // Stored nibbles come back from their own address only
  task automatic t_access();
    selHi <= 1'b1;
    i_rtcsc_host.wr(1'b0, 4'h3, 4'ha);
    i_rtcsc_host.wr(1'b0, 4'h4, 4'h5);
    chk("idle oe", 4'h1, {3'h0, busOeN});
    i_rtcsc_host.rd(4'h3, d, oe);
    chk("read 3", 4'ha, d);
    i_rtcsc_host.rd(4'h4, d, oe);
    chk("read 4", 4'h5, d);
  endtask : t_access

  // Wrong selects neither store nor drive
  task automatic t_refuse();
    i_rtcsc_host.wr(1'b1, 4'h3, 4'h6);
    i_rtcsc_host.rd(4'h3, d, oe);
    chk("refused write", 4'ha, d);
    selHi <= 1'b0;
    i_rtcsc_host.rd(4'h3, d, oe);
    chk("unselected oe", 4'h1, {3'h0, oe});
  endtask : t_refuse

  // Gating by secondary select, source pin and enable bit
  task automatic t_clock();
    i_rtcsc_host.cyc(8);
    chk("cs low oe", 4'h1, {3'h0, clkOeN});
    selHi <= 1'b1;
    i_rtcsc_host.cyc(8);
    chk("crystal oe", 4'h0, {3'h0, clkOeN});
    count_toggles(6200, toggles);
    chk_range("crystal toggles", 4, 5, toggles);
    srcPin <= 1'b1;
    i_rtcsc_host.cyc(8);
    chk("enable off oe", 4'h1, {3'h0, clkOeN});
    chk("enable off pin", 4'h0, {3'h0, clkPin});
    i_rtcsc_host.wr(1'b0, 4'hf, 4'h9);
    i_rtcsc_host.cyc(8);
    chk("divided oe", 4'h0, {3'h0, clkOeN});
    count_toggles(6200, toggles);
    chk_range("divided toggles", 2, 3, toggles);
    ce <= 1'b0;
    selHi <= 1'b0;
    i_rtcsc_host.cyc(6);
    chk("frozen oe", 4'h0, {3'h0, clkOeN});
    ce <= 1'b1;
    i_rtcsc_host.cyc(6);
    chk("released oe", 4'h1, {3'h0, clkOeN});
  endtask : t_clock

  // Reset, arming wait, scenarios, verdict
  initial begin
    repeat (8) @(posedge mclk);
    rst <= 1'b0;
    i_rtcsc_host.cyc(5); // Primary select seen high first
    t_access();
    t_refuse();
    t_clock();
    finish_test();
  end

  // Watchdog: the scenarios need about 13000 cycles
  initial begin
    repeat (30000) @(posedge mclk);
    fails++;
    $display("unexpected run length: expected done seen timeout");
    finish_test();
  end
endmodule : rtcsc_tb_top
